/* logic/quad_conv_pkg.sv */
// constants and types for the quad converter host controller
// assumes a 100 MHz core clock driving the converter's parallel pins
package quad_conv_pkg;
  localparam int          CHANNELS      = 4;
  localparam int          DATA_W        = 12;
  localparam int          CLK_PERIOD_NS = 10;
  // setup of data/select before strobe, strobe width, hold after strobe
  localparam int          SETUP_NS      = 20;
  localparam int          STROBE_NS     = 50;
  localparam int          HOLD_NS       = 10;
  localparam int          SETUP_CYC     =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STROBE_CYC    =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HOLD_CYC      =
    (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 4;
  localparam logic [11:0] MIDSCALE_CODE = 12'h800;
  localparam logic [11:0] MSB_FLIP      = 12'h800;
  localparam logic [3:0]  ALL_LOADED    = 4'hF;
  localparam logic [3:0]  NONE_LOADED   = 4'h0;

  typedef logic [DATA_W-1:0]   word_t;
  typedef logic [CHANNELS-1:0] chan_mask_t;
  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_LOAD} op_t;
endpackage : quad_conv_pkg

/* logic/strobe_if.sv */
// carries one strobe request from the sequencer to the pin timer
// assumes both ends share the core clock
`timescale 1ns/1ps
interface strobe_if;
  import quad_conv_pkg::*;
  logic start;
  op_t  op;
  logic busy;
  logic done;
  modport seq   (output start, output op, input busy, input done);
  modport timer (input start, input op, output busy, output done);
endinterface : strobe_if

/* logic/strobe_timer.sv */
// counts setup, strobe-low and hold phases for one pin access
// assumes start is only raised while busy is low
`timescale 1ns/1ps
module strobe_timer
  import quad_conv_pkg::*;
(
  input  wire logic CORE_CLK_I,
  input  wire logic SYS_RST_I,
  strobe_if.timer   sif,
  output      logic strobe_low_o
);
  typedef enum {T_IDLE, T_SETUP, T_STROBE, T_HOLD} tstate_t;
  tstate_t          state_reg;
  logic [CNT_W-1:0] cnt_reg;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg    <= T_IDLE;
      cnt_reg      <= '0;
      strobe_low_o <= 1'b0;
      sif.done     <= 1'b0;
    end else begin
      sif.done <= 1'b0;
      case (state_reg)
        T_IDLE: begin
          if (sif.start && sif.op != OP_NONE) begin
            state_reg <= T_SETUP;
            cnt_reg   <= cyc(SETUP_CYC);
          end
        end
        T_SETUP: begin
          if (cnt_reg == '0) begin
            state_reg    <= T_STROBE;
            cnt_reg      <= cyc(STROBE_CYC);
            strobe_low_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        T_STROBE: begin
          if (cnt_reg == '0) begin
            // releasing the strobe is the closing edge of the latches
            state_reg    <= T_HOLD;
            cnt_reg      <= cyc(HOLD_CYC);
            strobe_low_o <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        T_HOLD: begin
          if (cnt_reg == '0) begin
            state_reg <= T_IDLE;
            sif.done  <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= T_IDLE;
      endcase
    end
  end

  assign sif.busy = (state_reg != T_IDLE);
endmodule : strobe_timer

/* logic/quad_conv_host.sv */
// host controller for a double-buffered quad 12-bit converter
// assumes the converter pins are wired straight to the outputs below
// Functional notes
// - after reset rewrite all inputs before load
// - two's complement needs msb inverted
// - one select low plus write strobe
// - load with write updates all outputs
// - write strobe is the timing edge
// - write strobe low needed except reset
`timescale 1ns/1ps
module quad_conv_host
  import quad_conv_pkg::*;
(
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     SYS_RST_I,
  input  wire logic                     WR_REQ_I,
  input  wire logic [1:0]               WR_CHAN_I,
  input  wire quad_conv_pkg::word_t     WR_DATA_I,
  input  wire logic                     TWOS_COMP_I,
  input  wire logic                     LOAD_REQ_I,
  input  wire logic                     CLR_REQ_I,
  output      logic                     BUSY_O,
  output      logic                     DONE_O,
  output      logic                     LOAD_REFUSED_O,
  output      quad_conv_pkg::chan_mask_t LOADED_O,
  output      quad_conv_pkg::word_t     DATA_O,
  output      quad_conv_pkg::chan_mask_t CHANNEL_SELECT_N_O,
  output      logic                     WRITE_STROBE_N_O,
  output      logic                     LOAD_ALL_OUTPUTS_N_O,
  output      logic                     CONV_RESET_O
);
  import quad_conv_pkg::*;

  typedef enum {S_IDLE, S_RUN, S_CLEAR} state_t;

  strobe_if sif();
  state_t     state_reg;
  op_t        op_reg;
  logic       start_reg;
  logic       strobe_low;
  chan_mask_t loaded_reg;
  chan_mask_t sel_reg;
  logic       load_all_outputs_n_reg;

  function automatic chan_mask_t onehot(input logic [1:0] ch);
    onehot = chan_mask_t'(4'h1 << ch);
  endfunction : onehot

  function automatic word_t to_offset(input word_t w, input logic tc);
    to_offset = tc ? (w ^ MSB_FLIP) : w;
  endfunction : to_offset

  strobe_timer u_timer (
    .CORE_CLK_I   (CORE_CLK_I),
    .SYS_RST_I    (SYS_RST_I),
    .sif          (sif.timer),
    .strobe_low_o (strobe_low)
  );

  assign sif.start = start_reg;
  assign sif.op    = op_reg;

  // sequencer: one pin access at a time
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg      <= S_IDLE;
      op_reg         <= OP_NONE;
      start_reg      <= 1'b0;
      DONE_O         <= 1'b0;
      LOAD_REFUSED_O <= 1'b0;
      BUSY_O         <= 1'b0;
    end else begin
      start_reg      <= 1'b0;
      DONE_O         <= 1'b0;
      LOAD_REFUSED_O <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (CLR_REQ_I) begin
            state_reg <= S_CLEAR;
            BUSY_O    <= 1'b1;
          end else if (WR_REQ_I) begin
            op_reg    <= OP_WRITE;
            start_reg <= 1'b1;
            state_reg <= S_RUN;
            BUSY_O    <= 1'b1;
          end else if (LOAD_REQ_I) begin
            if (loaded_reg == ALL_LOADED) begin
              op_reg    <= OP_LOAD;
              start_reg <= 1'b1;
              state_reg <= S_RUN;
              BUSY_O    <= 1'b1;
            end else begin
              LOAD_REFUSED_O <= 1'b1;
            end
          end
        end
        S_RUN: begin
          if (sif.done) begin
            state_reg <= S_IDLE;
            BUSY_O    <= 1'b0;
            DONE_O    <= 1'b1;
          end
        end
        S_CLEAR: begin
          // reset pulse lasts one cycle, no strobe needed
          state_reg <= S_IDLE;
          BUSY_O    <= 1'b0;
          DONE_O    <= 1'b1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // data bus and select held stable across setup, strobe and hold
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      DATA_O   <= MIDSCALE_CODE;
      sel_reg  <= '0;
      load_all_outputs_n_reg <= 1'b0;
    end else if (state_reg == S_IDLE && !CLR_REQ_I && WR_REQ_I) begin
      DATA_O   <= to_offset(WR_DATA_I, TWOS_COMP_I);
      sel_reg  <= onehot(WR_CHAN_I);
      load_all_outputs_n_reg <= 1'b0;
    end else if (state_reg == S_IDLE && !CLR_REQ_I && LOAD_REQ_I
                 && loaded_reg == ALL_LOADED) begin
      sel_reg  <= '0;
      load_all_outputs_n_reg <= 1'b1;
    end else if (state_reg == S_IDLE) begin
      sel_reg  <= '0;
      load_all_outputs_n_reg <= 1'b0;
    end
  end

  // pins: only the write strobe is timed, select and load frame it
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      CHANNEL_SELECT_N_O   <= '1;
      WRITE_STROBE_N_O     <= 1'b1;
      LOAD_ALL_OUTPUTS_N_O <= 1'b1;
    end else begin
      CHANNEL_SELECT_N_O   <= ~sel_reg;
      WRITE_STROBE_N_O     <= ~strobe_low;
      LOAD_ALL_OUTPUTS_N_O <= ~load_all_outputs_n_reg;
    end
  end

  // converter reset drives the output latches to midscale without strobes
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      CONV_RESET_O <= 1'b1;
    end else begin
      CONV_RESET_O <= (state_reg == S_CLEAR);
    end
  end

  // track which input latches hold fresh data since the last clear
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      loaded_reg <= NONE_LOADED;
    end else if (state_reg == S_CLEAR) begin
      loaded_reg <= NONE_LOADED;
    end else if (sif.done && op_reg == OP_WRITE) begin
      loaded_reg <= loaded_reg | sel_reg;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      LOADED_O <= NONE_LOADED;
    end else begin
      LOADED_O <= loaded_reg;
    end
  end
endmodule : quad_conv_host

/* bench/quad_conv_host_asserts.sv */
// pin-timing checks for the converter host controller
// assumes it is bound to quad_conv_host and sees only its ports
`timescale 1ns/1ps
module quad_conv_host_asserts
  import quad_conv_pkg::*;
(
  input wire logic       CORE_CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       LOAD_REFUSED_O,
  input wire word_t      DATA_O,
  input wire chan_mask_t CHANNEL_SELECT_N_O,
  input wire logic       WRITE_STROBE_N_O,
  input wire logic       LOAD_ALL_OUTPUTS_N_O,
  input wire logic       CONV_RESET_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  strobe_width_a: assert property ($fell(WRITE_STROBE_N_O) |->
    (!WRITE_STROBE_N_O)[*5] ##1 WRITE_STROBE_N_O) else $error("strobe");
  one_select_a: assert property (!WRITE_STROBE_N_O |->
    $countones(~CHANNEL_SELECT_N_O) <= 1) else $error("selects");
  load_alone_a: assert property (!LOAD_ALL_OUTPUTS_N_O |->
    &CHANNEL_SELECT_N_O) else $error("load with select");
  data_steady_a: assert property (!WRITE_STROBE_N_O |->
    $stable(DATA_O)) else $error("data moved");
  qual_steady_a: assert property (!WRITE_STROBE_N_O |->
    $stable(CHANNEL_SELECT_N_O) && $stable(LOAD_ALL_OUTPUTS_N_O))
    else $error("qualifier moved");
  refuse_quiet_a: assert property (LOAD_REFUSED_O |->
    WRITE_STROBE_N_O && LOAD_ALL_OUTPUTS_N_O) else $error("refused");
  clear_pulse_a: assert property ($rose(CONV_RESET_O) |->
    ##1 !CONV_RESET_O) else $error("clear pulse");
  qual_first_a: assert property ($fell(WRITE_STROBE_N_O) |->
    !(&CHANNEL_SELECT_N_O && LOAD_ALL_OUTPUTS_N_O)) else $error("qual");
endmodule : quad_conv_host_asserts

bind quad_conv_host quad_conv_host_asserts chk (.*);

/* bench/quad_conv_model.sv */
// behavioural two-rank latch model of the quad converter
// assumes active-low qualifiers and an active-high async reset
`timescale 1ns/1ps
module quad_conv_model
  import quad_conv_pkg::*;
(
  input  wire word_t      data_i,
  input  wire chan_mask_t sel_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       ld_n_i,
  input  wire logic       rst_i,
  output      word_t      out_o [CHANNELS]
);
  word_t in_reg [CHANNELS];
  // input latches are not touched by reset, so they power up unknown
  always_latch begin
    for (int i = 0; i < CHANNELS; i++)
      if (!wr_n_i && !sel_n_i[i]) in_reg[i] = data_i;
  end
  always_latch begin
    for (int i = 0; i < CHANNELS; i++)
      if (rst_i) out_o[i] = MIDSCALE_CODE;
      else if (!wr_n_i && !ld_n_i) out_o[i] = in_reg[i];
  end
endmodule : quad_conv_model

/* bench/tb_quad_conv_host.sv */
// self-checking bench: host controller driving the converter model
// assumes 100 MHz clock and requests taken only while idle
`timescale 1ns/1ps
module tb_quad_conv_host;
  import quad_conv_pkg::*;
  typedef struct {logic [1:0] ch; word_t d; logic tc; word_t e;} row_t;
  logic       clk, rst, wr, ld, clr, tc, busy, done, refd;
  logic [1:0] ch;
  word_t      d, bus;
  chan_mask_t loaded, sel_n;
  logic       wr_n, ld_n, crst;
  word_t      out [CHANNELS];
  int         error_cnt = 0;
  int         checks = 0;
  row_t       rows [4] = '{'{0, 12'h000, 0, 12'h000},
    '{1, 12'hFFF, 0, 12'hFFF}, '{2, 12'h000, 1, 12'h800},
    '{3, 12'h7FF, 1, 12'hFFF}};
  quad_conv_host uut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .WR_REQ_I(wr),
    .WR_CHAN_I(ch), .WR_DATA_I(d), .TWOS_COMP_I(tc), .LOAD_REQ_I(ld),
    .CLR_REQ_I(clr), .BUSY_O(busy), .DONE_O(done), .LOAD_REFUSED_O(refd),
    .LOADED_O(loaded), .DATA_O(bus), .CHANNEL_SELECT_N_O(sel_n),
    .WRITE_STROBE_N_O(wr_n), .LOAD_ALL_OUTPUTS_N_O(ld_n),
    .CONV_RESET_O(crst));
  quad_conv_model conv (.data_i(bus), .sel_n_i(sel_n), .wr_n_i(wr_n),
    .ld_n_i(ld_n), .rst_i(crst), .out_o(out));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input word_t e, input word_t g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task chk_all(input word_t e [CHANNELS]);
    for (int i = 0; i < CHANNELS; i++) chk("output", e[i], out[i]);
  endtask : chk_all
  // one request held for one edge, then a bounded wait for its answer
  task op(input logic w, input logic l, input logic c, input logic [1:0] cn,
          input word_t dv, input logic t, input logic ref_e);
    int n;
    n = 0;
    @(posedge clk);
    {wr, ld, clr} <= {w, l, c};
    ch <= cn;
    d  <= dv;
    tc <= t;
    @(posedge clk);
    {wr, ld, clr} <= 3'h0;
    @(negedge clk);
    chk("busy", word_t'(!ref_e), word_t'(busy));
    while (done !== 1'b1 && refd !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk("timeout", '0, word_t'(n >= 30));
    chk("refused", word_t'(ref_e), word_t'(refd));
    chk("done", word_t'(!ref_e), word_t'(done));
  endtask : op
  task final_report;
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rst, wr, ld, clr, tc, ch, d} = {1'b1, 18'h0};
    repeat (3) @(posedge clk);
    rst <= 0;
    chk_all('{4{MIDSCALE_CODE}});
    op(0, 1, 0, 2'h0, 12'h000, 0, 1);
    foreach (rows[i])
      op(1, 0, 0, rows[i].ch, rows[i].d, rows[i].tc, 0);
    // the loaded mask is a registered copy, one cycle behind done
    @(negedge clk);
    chk("loaded", ALL_LOADED, loaded);
    chk_all('{4{MIDSCALE_CODE}});
    op(0, 1, 0, 2'h0, 12'h000, 0, 0);
    foreach (rows[i]) chk("output", rows[i].e, out[rows[i].ch]);
    op(1, 0, 0, 2'h3, 12'h123, 0, 0);
    chk_all('{12'h000, 12'hFFF, 12'h800, 12'hFFF});
    op(0, 0, 1, 2'h0, 12'h000, 0, 0);
    chk_all('{4{MIDSCALE_CODE}});
    op(0, 1, 0, 2'h0, 12'h000, 0, 1);
    foreach (rows[i])
      op(1, 0, 0, 2'(3 - i), rows[i].d, rows[i].tc, 0);
    chk_all('{4{MIDSCALE_CODE}});
    op(0, 1, 0, 2'h0, 12'h000, 0, 0);
    chk_all('{12'hFFF, 12'h800, 12'hFFF, 12'h000});
    // a host reset while idle parks the outputs and forgets all writes
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_all('{4{MIDSCALE_CODE}});
    chk("loaded", NONE_LOADED, loaded);
    op(0, 1, 0, 2'h0, 12'h000, 0, 1);
    final_report();
  end
endmodule : tb_quad_conv_host
